// ---- verilog/nomc_cfg.svh ----
// Purpose: offsets, field positions and reset values of the mode control bank
// Assumes: 8-bit registers on a byte-addressed plain register port
// Notes: definitions only
`ifndef NOMC_CFG_SVH
`define NOMC_CFG_SVH
// register offsets
`define NOMC_ADDR_OP_CTRL 8'h02
`define NOMC_ADDR_MODE_DEF 8'h03
`define NOMC_ADDR_AUX_CFG 8'h10
`define NOMC_ADDR_STATUS 8'h11
// operation_control fields
`define NOMC_OC_EN 7
`define NOMC_OC_RX_EN 6
`define NOMC_OC_RX_CHN 5
`define NOMC_OC_RX_MAN 4
`define NOMC_OC_TX_EN 3
`define NOMC_OC_WU 2
`define NOMC_OC_EFD_HI 1
`define NOMC_OC_EFD_LO 0
// mode_definition fields
`define NOMC_MD_TARG 7
`define NOMC_MD_PS_HI 6
`define NOMC_MD_PS_LO 3
`define NOMC_MD_MOD 2
`define NOMC_MD_AR_HI 1
`define NOMC_MD_AR_LO 0
// aux config fields
`define NOMC_AUX_CHOICE 0
`define NOMC_AUX_TFE 1
`define NOMC_AUX_PTD_HI 5
`define NOMC_AUX_PTD_LO 2
// status fields
`define NOMC_ST_XTAL 0
`define NOMC_ST_LPNFC 1
`define NOMC_ST_LEGAL 2
`define NOMC_ST_BRD 3
`define NOMC_ST_TXON 4
`define NOMC_ST_RXON 5
`define NOMC_ST_TFE_CONFLICT 6
// reset values, loaded at power-up only
`define NOMC_OC_RST 8'h00
`define NOMC_MD_RST 8'h08
`define NOMC_AUX_RST 8'h00
`endif

// ---- verilog/nomc_pkg.sv ----
// Purpose: types of the mode control bank
// Assumes: nothing
// Notes: numbers live in nomc_cfg.svh
package nomc_pkg;
  // external field detector setting
  typedef enum logic [1:0] {
    NOMC_EFD_OFF = 2'b00,
    NOMC_EFD_MAN_CA = 2'b01,
    NOMC_EFD_MAN_PEER = 2'b10,
    NOMC_EFD_AUTO = 2'b11
  } nomc_efd_t;
  // automatic response field setting
  typedef enum logic [1:0] {
    NOMC_AR_OFF = 2'b00,
    NOMC_AR_ANY_RX = 2'b01,
    NOMC_AR_PEER_OFF = 2'b10,
    NOMC_AR_RSVD = 2'b11
  } nomc_ar_t;
  // decoded protocol of role plus mode field
  typedef enum logic [3:0] {
    NOMC_P_NONE = 4'b0000,
    NOMC_P_ACTIVE = 4'b0001,
    NOMC_P_ISOA = 4'b0010,
    NOMC_P_ISOB = 4'b0011,
    NOMC_P_NFCF = 4'b0100,
    NOMC_P_T1T = 4'b0101,
    NOMC_P_SUBC = 4'b0110,
    NOMC_P_BPSK = 4'b0111,
    NOMC_P_PT_ISOA = 4'b1000,
    NOMC_P_PT_NFCF = 4'b1001,
    NOMC_P_T_ACTIVE = 4'b1010,
    NOMC_P_BRD = 4'b1011
  } nomc_proto_t;
endpackage

// ---- verilog/nomc_sync.sv ----
// Purpose: two-flop synchroniser for a level from outside the clock domain
// Assumes: input is a slow level
// Notes: first flop is read by the second only
`timescale 1ns/1ns
module nomc_sync (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q;
  // two stages, cleared at power-up
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule

// ---- verilog/nomc_top.sv ----
// Purpose: operating state and protocol mode control of the nfc front end
// Assumes: 20 MHz clk_sys, arst_n is the power-on reset
// Notes: two 8-bit control registers plus aux config and status words
`timescale 1ns/1ns
`include "nomc_cfg.svh"

module nomc_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic xtalStablePin,
  input wire logic fieldOnCmd,
  input wire logic txDone,
  input wire logic rxEndAny,
  input wire logic peerFieldOff,
  output logic oscRegEnable,
  output logic rxEnable,
  output logic rxAmEn,
  output logic rxPmEn,
  output logic rxAutoSel,
  output logic txEnable,
  output logic wakeupEnable,
  output logic efdOn,
  output logic efdPeerThresh,
  output logic efdAuto,
  output logic lowPowerNfc,
  output logic roleTarget,
  output nomc_pkg::nomc_proto_t protocol,
  output logic modAm,
  output logic brdNfcfEn,
  output logic brdIsoaEn,
  output logic useTargetDrive,
  output logic [3:0] driveStrength,
  output logic respFieldOn
);
  import nomc_pkg::*;

  logic [7:0] opCtrl_q;
  logic [7:0] modeDef_q;
  logic [7:0] auxCfg_q;
  logic xtalOk;
  logic selOc;
  logic selMd;
  logic selAux;
  logic selSt;
  logic ocWrite;
  logic mdWrite;
  logic auxWrite;
  logic [3:0] psField;
  logic isTarget;
  logic modeLegal;
  logic activeMode;
  logic isBrd;
  logic isPassiveTarget;
  logic respStart;
  logic txSet;
  logic txClear;
  logic lowPowerD;
  logic rxOnD;
  logic txOnD;
  logic pathChoice;
  nomc_efd_t efdSel;
  nomc_ar_t arSel;
  nomc_proto_t protoD;
  logic [7:0] statusWord;
  logic [7:0] rdataD;

  // crystal stable level comes from the analog side
  nomc_sync uXtalSync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .asyncIn(xtalStablePin),
    .syncOut(xtalOk)
  );

  // address decode
  assign selOc = (regAddr == ADDR_W'(`NOMC_ADDR_OP_CTRL));
  assign selMd = (regAddr == ADDR_W'(`NOMC_ADDR_MODE_DEF));
  assign selAux = (regAddr == ADDR_W'(`NOMC_ADDR_AUX_CFG));
  assign selSt = (regAddr == ADDR_W'(`NOMC_ADDR_STATUS));
  assign ocWrite = regWrite && selOc;
  assign mdWrite = regWrite && selMd && xtalOk;
  assign auxWrite = regWrite && selAux;

  // field views of the stored words
  assign psField = modeDef_q[`NOMC_MD_PS_HI:`NOMC_MD_PS_LO];
  assign isTarget = modeDef_q[`NOMC_MD_TARG];
  assign efdSel = nomc_efd_t'(opCtrl_q[`NOMC_OC_EFD_HI:`NOMC_OC_EFD_LO]);
  assign arSel = nomc_ar_t'(modeDef_q[`NOMC_MD_AR_HI:`NOMC_MD_AR_LO]);
  assign pathChoice = auxCfg_q[`NOMC_AUX_CHOICE];

  // protocol decode per role
  always_comb begin
    protoD = NOMC_P_NONE;
    if (!isTarget) begin
      unique case (psField)
        4'h0: protoD = NOMC_P_ACTIVE;
        4'h1: protoD = NOMC_P_ISOA;
        4'h2: protoD = NOMC_P_ISOB;
        4'h3: protoD = NOMC_P_NFCF;
        4'h4: protoD = NOMC_P_T1T;
        4'he: protoD = NOMC_P_SUBC;
        4'hf: protoD = NOMC_P_BPSK;
        default: protoD = NOMC_P_NONE;
      endcase
    end else if (psField[3]) begin
      protoD = NOMC_P_BRD;
    end else begin
      unique case (psField)
        4'h1: protoD = NOMC_P_PT_ISOA;
        4'h4: protoD = NOMC_P_PT_NFCF;
        4'h7: protoD = NOMC_P_T_ACTIVE;
        default: protoD = NOMC_P_NONE;
      endcase
    end
  end

  // mode classes derived from the decode
  assign modeLegal = (protoD != NOMC_P_NONE);
  assign isBrd = (protoD == NOMC_P_BRD);
  assign activeMode = (protoD == NOMC_P_ACTIVE) || (protoD == NOMC_P_T_ACTIVE);
  assign isPassiveTarget = (protoD == NOMC_P_PT_ISOA) || (protoD == NOMC_P_PT_NFCF);

  // automatic response field-on trigger
  always_comb begin
    respStart = 1'b0;
    unique case (arSel)
      NOMC_AR_OFF: respStart = 1'b0;
      NOMC_AR_ANY_RX: respStart = rxEndAny;
      NOMC_AR_PEER_OFF: respStart = peerFieldOff;
      NOMC_AR_RSVD: respStart = 1'b0;
    endcase
  end

  // hardware set and clear of the tx enable bit
  assign txSet = fieldOnCmd || respStart;
  assign txClear = txDone && activeMode;

  // operation control register, power-up defaults only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      opCtrl_q <= `NOMC_OC_RST;
    end else begin
      if (ocWrite) begin
        opCtrl_q <= regWdata;
      end
      if (txClear) begin
        opCtrl_q[`NOMC_OC_TX_EN] <= 1'b0;
      end
      if (txSet) begin
        opCtrl_q[`NOMC_OC_TX_EN] <= 1'b1; // set wins over any clear
      end
    end
  end

  // mode definition register, guarded by crystal stable
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      modeDef_q <= `NOMC_MD_RST;
    end else if (mdWrite) begin
      modeDef_q <= regWdata;
    end
  end

  // aux config: path choice, transport frames, target drive strength
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      auxCfg_q <= `NOMC_AUX_RST;
    end else if (auxWrite) begin
      auxCfg_q <= {2'b00, regWdata[5:0]};
    end
  end

  // low power initial mode and effective path enables
  assign lowPowerD = (efdSel != NOMC_EFD_OFF) && (opCtrl_q[7:2] == 6'h00);
  assign rxOnD = opCtrl_q[`NOMC_OC_RX_EN] && modeLegal;
  assign txOnD = opCtrl_q[`NOMC_OC_TX_EN] && modeLegal;

  // status word for software
  always_comb begin
    statusWord = 8'h00;
    statusWord[`NOMC_ST_XTAL] = xtalOk;
    statusWord[`NOMC_ST_LPNFC] = lowPowerD;
    statusWord[`NOMC_ST_LEGAL] = modeLegal;
    statusWord[`NOMC_ST_BRD] = isBrd;
    statusWord[`NOMC_ST_TXON] = txOnD;
    statusWord[`NOMC_ST_RXON] = rxOnD;
    // transport frames are not allowed in detection mode
    statusWord[`NOMC_ST_TFE_CONFLICT] = isBrd && auxCfg_q[`NOMC_AUX_TFE];
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdataD = 8'h00;
    if (regRead) begin
      if (selOc) begin
        rdataD = opCtrl_q;
      end else if (selMd) begin
        rdataD = modeDef_q;
      end else if (selAux) begin
        rdataD = auxCfg_q;
      end else if (selSt) begin
        rdataD = statusWord;
      end
    end
  end

  // read data stand for the one cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= rdataD;
    end
  end

  // power, wake-up and low power outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      oscRegEnable <= 1'b0;
      wakeupEnable <= 1'b0;
      lowPowerNfc <= 1'b0;
    end else begin
      oscRegEnable <= opCtrl_q[`NOMC_OC_EN];
      wakeupEnable <= opCtrl_q[`NOMC_OC_WU];
      lowPowerNfc <= lowPowerD;
    end
  end

  // receiver enable and channel selection
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxEnable <= 1'b0;
      rxAmEn <= 1'b0;
      rxPmEn <= 1'b0;
      rxAutoSel <= 1'b0;
    end else begin
      rxEnable <= rxOnD;
      if (!rxOnD) begin
        rxAmEn <= 1'b0;
        rxPmEn <= 1'b0;
        rxAutoSel <= 1'b0;
      end else if (opCtrl_q[`NOMC_OC_RX_CHN]) begin
        // single channel, picked by path choice: 0 am, 1 pm
        rxAmEn <= !pathChoice;
        rxPmEn <= pathChoice;
        rxAutoSel <= 1'b0;
      end else begin
        rxAmEn <= 1'b1;
        rxPmEn <= 1'b1;
        rxAutoSel <= !opCtrl_q[`NOMC_OC_RX_MAN];
      end
    end
  end

  // transmitter enable follows the stored bit gated by a legal mode
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      txEnable <= 1'b0;
    end else begin
      txEnable <= txOnD;
    end
  end

  // external field detector decode
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      efdOn <= 1'b0;
      efdPeerThresh <= 1'b0;
      efdAuto <= 1'b0;
    end else begin
      unique case (efdSel)
        NOMC_EFD_OFF: begin
          efdOn <= 1'b0;
          efdPeerThresh <= 1'b0;
          efdAuto <= 1'b0;
        end
        NOMC_EFD_MAN_CA: begin
          efdOn <= 1'b1;
          efdPeerThresh <= 1'b0;
          efdAuto <= 1'b0;
        end
        NOMC_EFD_MAN_PEER: begin
          efdOn <= 1'b1;
          efdPeerThresh <= 1'b1;
          efdAuto <= 1'b0;
        end
        NOMC_EFD_AUTO: begin
          efdOn <= 1'b1;
          efdPeerThresh <= 1'b0;
          efdAuto <= 1'b1;
        end
      endcase
    end
  end

  // role, protocol and modulation
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      roleTarget <= 1'b0;
      protocol <= NOMC_P_NONE;
      modAm <= 1'b0;
    end else begin
      roleTarget <= isTarget;
      protocol <= protoD;
      modAm <= modeDef_q[`NOMC_MD_MOD];
    end
  end

  // bit rate detection sub-enables, middle sub-bit reserved
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      brdNfcfEn <= 1'b0;
      brdIsoaEn <= 1'b0;
    end else begin
      brdNfcfEn <= isBrd && psField[2];
      brdIsoaEn <= isBrd && psField[0];
    end
  end

  // target drive strength in passive target and detection modes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      useTargetDrive <= 1'b0;
      driveStrength <= 4'h0;
    end else begin
      useTargetDrive <= isPassiveTarget || isBrd;
      if (isPassiveTarget || isBrd) begin
        driveStrength <= auxCfg_q[`NOMC_AUX_PTD_HI:`NOMC_AUX_PTD_LO];
      end else begin
        driveStrength <= 4'h0;
      end
    end
  end

  // one-cycle request to start response collision avoidance
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      respFieldOn <= 1'b0;
    end else begin
      respFieldOn <= respStart;
    end
  end
endmodule

// ---- tb/nomc_props.sv ----
// Purpose: port-level checks of the mode control bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to nomc_top at the foot of this file
`timescale 1ns/1ns
module nomc_props #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic xtalStablePin,
  input wire logic fieldOnCmd,
  input wire logic txDone,
  input wire logic rxEndAny,
  input wire logic peerFieldOff,
  input wire logic oscRegEnable,
  input wire logic rxEnable,
  input wire logic rxAmEn,
  input wire logic rxPmEn,
  input wire logic txEnable,
  input wire logic wakeupEnable,
  input wire logic efdOn,
  input wire logic efdAuto,
  input wire logic lowPowerNfc,
  input wire logic roleTarget,
  input wire nomc_pkg::nomc_proto_t protocol,
  input wire logic modAm,
  input wire logic useTargetDrive,
  input wire logic [3:0] driveStrength,
  input wire logic respFieldOn
);
  import nomc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [2:0] hiCnt_q;
  // edges with the crystal pin high, saturating, so the sync delay is covered
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hiCnt_q <= 3'h0;
    end else if (!xtalStablePin) begin
      hiCnt_q <= 3'h0;
    end else if (hiCnt_q != 3'h4) begin
      hiCnt_q <= hiCnt_q + 3'h1;
    end
  end
  // lone op-control write with no event that could touch the tx bit
  sequence s_wr2;
    regWrite && regAddr == 8'h02 && !fieldOnCmd && !rxEndAny && !peerFieldOff && !txDone
      ##1 !(regWrite && regAddr == 8'h02);
  endsequence
  a_osc_follows_bit: assert property (s_wr2 |=> oscRegEnable == $past(regWdata[7], 2))
    else $error("oscillator enable does not follow bit 7");
  a_wakeup_follows_bit: assert property (s_wr2 |=> wakeupEnable == $past(regWdata[2], 2))
    else $error("wake-up enable does not follow bit 2");
  a_efd_decode: assert property (s_wr2 |=> efdOn == (|$past(regWdata[1:0], 2))
    && efdAuto == (&$past(regWdata[1:0], 2))) else $error("field detector decode wrong");
  a_low_power_entry: assert property (s_wr2 |=> lowPowerNfc ==
    ($past(regWdata[7:2], 2) == 6'h00 && $past(regWdata[1:0], 2) != 2'h0)) else $error("low power mode wrong");
  a_rx_channel_on: assert property ((rxAmEn || rxPmEn) == rxEnable)
    else $error("rx channel enables disagree with rx enable");
  a_illegal_mode_off: assert property (protocol == NOMC_P_NONE |-> !txEnable && !rxEnable)
    else $error("tx or rx on with unsupported mode");
  a_field_on_tx: assert property (fieldOnCmd ##2 protocol != NOMC_P_NONE |-> txEnable)
    else $error("field-on did not enable tx");
  a_mode_locked: assert property (regWrite && regAddr == 8'h03 && !xtalStablePin && !$past(xtalStablePin)
    && !$past(xtalStablePin, 2) |=> ##1 $stable(roleTarget) && $stable(modAm)) else $error("mode written unlocked");
  a_mode_accepted: assert property (regWrite && regAddr == 8'h03 && hiCnt_q == 3'h4
    ##1 !(regWrite && regAddr == 8'h03) |=> roleTarget == $past(regWdata[7], 2) && modAm == $past(regWdata[2], 2))
    else $error("mode write not taken");
  a_target_drive: assert property (useTargetDrive == (protocol inside {NOMC_P_PT_ISOA, NOMC_P_PT_NFCF, NOMC_P_BRD})
    && (useTargetDrive || driveStrength == 4'h0)) else $error("target drive selection wrong");
  a_resp_has_cause: assert property (respFieldOn |-> $past(rxEndAny) || $past(peerFieldOff))
    else $error("response field without an event");
  c_field_on: cover property (fieldOnCmd ##2 txEnable);
  c_low_power: cover property (lowPowerNfc);
  c_resp: cover property (respFieldOn);
endmodule

bind nomc_top nomc_props #(.ADDR_W(ADDR_W)) nomc_props_inst (.clk_sys, .arst_n, .regAddr, .regWdata, .regWrite,
  .xtalStablePin, .fieldOnCmd, .rxEndAny, .peerFieldOff, .oscRegEnable, .rxEnable, .rxAmEn, .rxPmEn, .txEnable,
  .wakeupEnable, .efdOn, .efdAuto, .lowPowerNfc, .roleTarget, .protocol, .modAm, .useTargetDrive, .driveStrength,
  .respFieldOn, .txDone);

// ---- tb/nomc_peer.sv ----
// Purpose: rf peer model giving reception, field and transmit events
// Assumes: events are one-cycle pulses on clk_sys
// Notes: pulse is called from the bench, with an optional stall
`timescale 1ns/1ns
module nomc_peer (
  input wire logic clk_sys,
  output logic rxEndAny,
  output logic peerFieldOff,
  output logic txDone
);
  // quiet far side until asked
  initial begin
    rxEndAny = 1'b0;
    peerFieldOff = 1'b0;
    txDone = 1'b0;
  end
  // one event after a stall: 0 reception end, 1 field removed, 2 tx finished
  task automatic pulse(input int k, input int stall);
    repeat (stall) @(posedge clk_sys);
    @(posedge clk_sys);
    rxEndAny <= (k == 0);
    peerFieldOff <= (k == 1);
    txDone <= (k == 2);
    @(posedge clk_sys);
    {rxEndAny, peerFieldOff, txDone} <= 3'h0;
  endtask
endmodule

// ---- tb/test_nfc_operation_mode_control.sv ----
// Purpose: self-checking bench of the mode control bank
// Assumes: 20 MHz clock, register port with one-cycle strobes
// Notes: outputs are checked two edges after the write that causes them
`timescale 1ns/1ns
module test_nfc_operation_mode_control;
  import nomc_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic xtalStablePin = 1'b0;
  logic fieldOnCmd = 1'b0;
  logic [7:0] regRdata, md;
  logic rxEndAny, peerFieldOff, txDone, oscRegEnable, rxEnable, rxAmEn, rxPmEn, rxAutoSel, txEnable;
  logic wakeupEnable, efdOn, efdPeerThresh, efdAuto, lowPowerNfc, roleTarget, modAm, brdNfcfEn, brdIsoaEn;
  logic useTargetDrive, respFieldOn, legal, tgt;
  logic [3:0] driveStrength;
  nomc_proto_t protocol, expP;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  // rx table: opctrl, aux, expected {rx, am, pm, auto}, mask
  logic [31:0] rxTab [5] = '{32'h4000_0f0f, 32'h5001_0e0f, 32'h6000_0c0e, 32'h6001_0a0e, 32'h2000_000e};
  nomc_top nomc_top_inst (.clk_sys, .arst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .xtalStablePin,
    .fieldOnCmd, .txDone, .rxEndAny, .peerFieldOff, .oscRegEnable, .rxEnable, .rxAmEn, .rxPmEn, .rxAutoSel,
    .txEnable, .wakeupEnable, .efdOn, .efdPeerThresh, .efdAuto, .lowPowerNfc, .roleTarget, .protocol, .modAm,
    .brdNfcfEn, .brdIsoaEn, .useTargetDrive, .driveStrength, .respFieldOn);
  nomc_peer nomc_peer_inst (.clk_sys, .rxEndAny, .peerFieldOff, .txDone);
  // 50 ns clock
  always #25 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // one write, then wait until its outputs have landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    chk(regRdata, exp, what);
  endtask
  // peer event, its response pulse and tx bit, then tx cleared by a late tx end
  task automatic ev(input int k, input logic want);
    nomc_peer_inst.pulse(k, 0);
    @(negedge clk_sys);
    chk({7'h0, respFieldOn}, {7'h0, want}, "resp");
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({7'h0, txEnable}, {7'h0, want}, "tx auto");
    nomc_peer_inst.pulse(2, 1);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({7'h0, txEnable}, 8'h00, "tx done");
  endtask
  function automatic nomc_proto_t protoOf(input logic [4:0] m);
    case (m)
      5'h00: return NOMC_P_ACTIVE;
      5'h01: return NOMC_P_ISOA;
      5'h02: return NOMC_P_ISOB;
      5'h03: return NOMC_P_NFCF;
      5'h04: return NOMC_P_T1T;
      5'h0e: return NOMC_P_SUBC;
      5'h0f: return NOMC_P_BPSK;
      5'h11: return NOMC_P_PT_ISOA;
      5'h14: return NOMC_P_PT_NFCF;
      5'h17: return NOMC_P_T_ACTIVE;
      default: return (m[4] && m[3]) ? NOMC_P_BRD : NOMC_P_NONE;
    endcase
  endfunction
  task automatic results();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(8'h02, 8'h00, "opctrl");
    rd(8'h03, 8'h08, "mode");
    rd(8'h20, 8'h00, "unmapped");
    wr(8'h03, 8'h80);
    rd(8'h03, 8'h08, "mode locked");
    @(posedge clk_sys);
    xtalStablePin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(8'h02, 8'h84);
    chk({6'h0, oscRegEnable, wakeupEnable}, 8'h03, "osc wu");
    rd(8'h02, 8'h84, "opctrl rb");
    wr(8'h02, 8'h00);
    chk({6'h0, oscRegEnable, wakeupEnable}, 8'h00, "osc wu off");
    $display("test power done");
    for (int i = 0; i < 5; i++) begin
      wr(8'h10, rxTab[i][23:16]);
      wr(8'h02, rxTab[i][31:24]);
      chk({4'h0, rxEnable, rxAmEn, rxPmEn, rxAutoSel} & rxTab[i][7:0], rxTab[i][15:8], "rx");
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h02, 8'(c));
      chk({4'h0, efdOn, efdPeerThresh, efdAuto, lowPowerNfc}, {4'h0, c != 0, c == 2, c == 3, c != 0}, "efd");
    end
    wr(8'h02, 8'h83);
    chk({7'h0, lowPowerNfc}, 8'h00, "low power busy");
    $display("test opctrl done");
    wr(8'h10, 8'h3c);
    wr(8'h02, 8'h4b);
    for (int m = 0; m < 32; m++) begin
      md = {m[4], m[3:0], 3'h0};
      expP = protoOf(5'(m));
      legal = (expP != NOMC_P_NONE);
      tgt = (expP inside {NOMC_P_PT_ISOA, NOMC_P_PT_NFCF, NOMC_P_BRD});
      wr(8'h03, md);
      rd(8'h03, md, "mode rb");
      chk({4'h0, protocol}, {4'h0, expP}, "protocol");
      chk({2'h0, rxEnable, txEnable, roleTarget, brdNfcfEn, brdIsoaEn, useTargetDrive},
        {2'h0, legal, legal, m[4], expP == NOMC_P_BRD && m[2], expP == NOMC_P_BRD && m[0], tgt}, "mode outs");
      chk({4'h0, driveStrength}, tgt ? 8'h0f : 8'h00, "drive");
    end
    rd(8'h11, 8'h3d, "status");
    $display("test modes done");
    wr(8'h02, 8'h43);
    for (int a = 0; a < 4; a++) begin
      wr(8'h03, 8'h04 | 8'(a));
      chk({7'h0, modAm}, 8'h01, "modulation");
      ev(0, a == 1);
      ev(1, a == 2);
    end
    wr(8'h03, 8'h08);
    wr(8'h02, 8'h41);
    @(posedge clk_sys);
    fieldOnCmd <= 1'b1;
    @(posedge clk_sys);
    fieldOnCmd <= 1'b0;
    nomc_peer_inst.pulse(2, 0);
    repeat (2) @(negedge clk_sys);
    chk({7'h0, txEnable}, 8'h01, "tx field on");
    rd(8'h02, 8'h49, "tx bit");
    $display("test events done");
    results();
  end
endmodule
